// *** rtl/ccr_params.svh ***
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// Register indices (word addresses) and reset values
`define CCR_IDX_SUPPLY_CFG 8'h07
`define CCR_IDX_CAL_EN 8'h08
`define CCR_RST_SUPPLY_CFG 16'h0000
`define CCR_RST_CAL_EN 16'h0000

// Supply configuration field positions
`define CCR_ARM_LO 0
`define CCR_ARM_HI 1
`define CCR_NCLAMP_LO 2
`define CCR_NCLAMP_HI 5
`define CCR_PCLAMP_LO 6
`define CCR_PCLAMP_HI 9
`define CCR_MODE_LO 10
`define CCR_MODE_HI 11

// Calibration enable bit position
`define CCR_CAL_EN_BIT 0

// Clamp codes valid in voltage output mode
`define CCR_NCLAMP_V0 4'h2
`define CCR_NCLAMP_V1 4'h7
`define CCR_NCLAMP_V2 4'h9
`define CCR_PCLAMP_V0 4'h3
`define CCR_PCLAMP_V1 4'h8
`define CCR_PCLAMP_V2 4'h9

// Answer unmapped reads with this word
`define CCR_UNMAPPED_DATA 32'h0000_0000

`endif

// *** rtl/ccr_pkg.sv ***
package ccr_pkg;

    typedef enum logic [1:0] {
        CCR_MODE_TRACK = 2'h0,
        CCR_MODE_USER = 2'h1,
        CCR_MODE_AUTO = 2'h2,
        CCR_MODE_BAD = 2'h3
    } ccr_mode_e;

    typedef enum logic [1:0] {
        CCR_ST_IDLE = 2'h0,
        CCR_ST_DONE = 2'h1
    } ccr_state_e;

endpackage

// *** rtl/ccr_reg16.sv ***
`timescale 1ns/1ps
`default_nettype none

module ccr_reg16 #(
    parameter logic [15:0] RESET_VALUE = 16'h0000
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // Write port
    input wire logic [15:0] wr_mask,
    input wire logic [15:0] wr_data,
    // Stored value
    output logic [15:0] value_q
);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            value_q <= RESET_VALUE;
        end
        else if (clk_en)
        begin
            value_q <= (value_q & ~wr_mask) | (wr_data & wr_mask);
        end
    end

endmodule

`default_nettype wire

// *** rtl/ccr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ccr_params.svh"

// Operation
// - Negative clamp code in supply config bits 5:2, reset 0000.
// - Arm select in bits 1:0, reset 00 keeps both arms off.
// - Arm select 01 enables positive arm only, 10 negative only.
// - Calibration applies to channel data only while enable bit 0 set.
// - Calibration enable register at 0x08, reset 0x0000, bits 15:0 storable.
// - Positive clamp code in bits 9:6, reset 0000.
// - Mode 00 tracking, 01 user clamps, 10 auto positive, 11 invalid.
module ccr_regs
    import ccr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Auto-learned positive clamp
    input wire logic auto_clamp_valid,
    input wire logic [3:0] auto_clamp_code,
    // Channel data path
    input wire logic [15:0] raw_data,
    input wire logic [15:0] cal_data,
    output logic [15:0] chan_data_q,
    // Supply controls
    output logic pos_arm_en_q,
    output logic neg_arm_en_q,
    output logic [3:0] negative_clamp_code_q,
    output logic [3:0] positive_clamp_code_q,
    output logic [1:0] clamp_setting_mode_q,
    output logic track_mode_q,
    output logic mode_invalid_q,
    output logic nclamp_volt_ok_q,
    output logic pclamp_volt_ok_q
);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    ccr_state_e state_q;
    logic req;
    logic hit_cfg;
    logic hit_cal;
    logic [15:0] lane_mask;
    logic [15:0] cfg_q;
    logic [15:0] cal_q;
    logic [15:0] cfg_mask;
    logic [15:0] cal_mask;
    logic [15:0] pclamp_field;
    logic [15:0] auto_mask;
    logic [15:0] auto_data;
    logic [15:0] cfg_wdata;
    logic [3:0] nclamp;
    logic [3:0] pclamp;
    logic [1:0] arm;

    assign req = (avs_read | avs_write) && state_q == CCR_ST_IDLE;
    assign hit_cfg = avs_address == `CCR_IDX_SUPPLY_CFG;
    assign hit_cal = avs_address == `CCR_IDX_CAL_EN;
    assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // One wait cycle per access: request taken in IDLE, answered in DONE
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= CCR_ST_IDLE;
            avs_waitrequest <= 1'b1;
        end
        else if (clk_en)
        begin
            case (state_q)
                CCR_ST_IDLE:
                begin
                    if (avs_read | avs_write)
                    begin
                        state_q <= CCR_ST_DONE;
                        avs_waitrequest <= 1'b0;
                    end
                end
                CCR_ST_DONE:
                begin
                    state_q <= CCR_ST_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default:
                begin
                    state_q <= CCR_ST_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (clk_en && req && avs_read)
        begin
            if (hit_cfg)
            begin
                avs_readdata <= {16'h0000, cfg_q};
            end
            else if (hit_cal)
            begin
                avs_readdata <= {16'h0000, cal_q};
            end
            else
            begin
                avs_readdata <= `CCR_UNMAPPED_DATA;
            end
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    assign pclamp_field = 16'h0000 | (16'h000f << `CCR_PCLAMP_LO);
    assign auto_data = {12'h000, auto_clamp_code} << `CCR_PCLAMP_LO;
    assign auto_mask = (clamp_setting_mode_q == CCR_MODE_AUTO && auto_clamp_valid) ? pclamp_field : 16'h0000;

    always_comb
    begin
        cfg_mask = 16'h0000;
        if (req && avs_write && hit_cfg)
        begin
            cfg_mask = lane_mask;
            if (clamp_setting_mode_q == CCR_MODE_AUTO)
            begin
                cfg_mask = cfg_mask & ~pclamp_field;
            end
        end
        cfg_mask = cfg_mask | auto_mask;
        cfg_wdata = (avs_writedata[15:0] & ~auto_mask) | (auto_data & auto_mask);
    end

    assign cal_mask = (req && avs_write && hit_cal) ? lane_mask : 16'h0000;

    ccr_reg16 #(
        .RESET_VALUE(`CCR_RST_SUPPLY_CFG)
    ) u_cfg (
        .clk(clk),
        .rst(rst),
        .clk_en(clk_en),
        .wr_mask(cfg_mask),
        .wr_data(cfg_wdata),
        .value_q(cfg_q)
    );

    ccr_reg16 #(
        .RESET_VALUE(`CCR_RST_CAL_EN)
    ) u_cal (
        .clk(clk),
        .rst(rst),
        .clk_en(clk_en),
        .wr_mask(cal_mask),
        .wr_data(avs_writedata[15:0]),
        .value_q(cal_q)
    );

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    assign nclamp = cfg_q[`CCR_NCLAMP_HI:`CCR_NCLAMP_LO];
    assign pclamp = cfg_q[`CCR_PCLAMP_HI:`CCR_PCLAMP_LO];
    assign arm = cfg_q[`CCR_ARM_HI:`CCR_ARM_LO];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pos_arm_en_q <= 1'b0;
            neg_arm_en_q <= 1'b0;
            negative_clamp_code_q <= 4'h0;
            positive_clamp_code_q <= 4'h0;
            clamp_setting_mode_q <= 2'h0;
            track_mode_q <= 1'b1;
            mode_invalid_q <= 1'b0;
        end
        else if (clk_en)
        begin
            pos_arm_en_q <= arm == 2'h1;
            neg_arm_en_q <= arm == 2'h2;
            negative_clamp_code_q <= nclamp;
            positive_clamp_code_q <= pclamp;
            clamp_setting_mode_q <= cfg_q[`CCR_MODE_HI:`CCR_MODE_LO];
            track_mode_q <= cfg_q[`CCR_MODE_HI:`CCR_MODE_LO] == CCR_MODE_TRACK;
            mode_invalid_q <= cfg_q[`CCR_MODE_HI:`CCR_MODE_LO] == CCR_MODE_BAD;
        end
    end

    // Voltage-mode validity flags for the stored clamp codes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            nclamp_volt_ok_q <= 1'b0;
            pclamp_volt_ok_q <= 1'b0;
        end
        else if (clk_en)
        begin
            nclamp_volt_ok_q <= nclamp == `CCR_NCLAMP_V0 || nclamp == `CCR_NCLAMP_V1
                || nclamp == `CCR_NCLAMP_V2;
            pclamp_volt_ok_q <= pclamp == `CCR_PCLAMP_V0 || pclamp == `CCR_PCLAMP_V1
                || pclamp == `CCR_PCLAMP_V2;
        end
    end

    // ------------------------------------------------------------
    // Calibration select
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            chan_data_q <= 16'h0000;
        end
        else if (clk_en)
        begin
            chan_data_q <= cal_q[`CCR_CAL_EN_BIT] ? cal_data : raw_data;
        end
    end

endmodule

`default_nettype wire

// *** sim/ccr_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_asserts
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    // Controls
    input wire logic auto_clamp_valid,
    input wire logic [3:0] auto_clamp_code,
    input wire logic pos_arm_en_q,
    input wire logic neg_arm_en_q,
    input wire logic [3:0] negative_clamp_code_q,
    input wire logic [3:0] positive_clamp_code_q,
    input wire logic [1:0] clamp_setting_mode_q,
    input wire logic track_mode_q,
    input wire logic mode_invalid_q,
    input wire logic nclamp_volt_ok_q,
    input wire logic pclamp_volt_ok_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // Checks
    // ----
    AST_TAKE: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
        else $error("request not answered");
    AST_ONE: assert property (!avs_waitrequest && clk_en |=> avs_waitrequest)
        else $error("wait low too long");
    AST_IDLE: assert property (!(avs_read || avs_write) && clk_en |=> avs_waitrequest)
        else $error("answer without request");
    AST_RHI: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
        else $error("upper read half set");
    AST_ARMS: assert property (!(pos_arm_en_q && neg_arm_en_q))
        else $error("both arms on");
    AST_NOK: assert property (nclamp_volt_ok_q == (negative_clamp_code_q inside {4'h2, 4'h7, 4'h9}))
        else $error("clamp flag wrong");
    AST_POK: assert property (pclamp_volt_ok_q == (positive_clamp_code_q inside {4'h3, 4'h8, 4'h9}))
        else $error("positive clamp flag wrong");
    AST_FRZ: assert property (!clk_en |=> $stable(avs_waitrequest) && $stable(negative_clamp_code_q)
        && $stable(positive_clamp_code_q) && $stable(clamp_setting_mode_q)) else $error("state moved while frozen");
    AST_TRACK: assert property (track_mode_q == (clamp_setting_mode_q == 2'h0))
        else $error("track flag wrong");
    AST_BAD: assert property (mode_invalid_q == (clamp_setting_mode_q == 2'h3))
        else $error("invalid flag wrong");
    AST_AUTO: assert property (auto_clamp_valid && clamp_setting_mode_q == 2'h2 && clk_en ##1 clk_en
        |=> positive_clamp_code_q == $past(auto_clamp_code, 2)) else $error("auto load missed");
    cover property (pos_arm_en_q);
    cover property (neg_arm_en_q);
    cover property (mode_invalid_q);
    cover property (auto_clamp_valid && clamp_setting_mode_q == 2'h2);
endmodule
bind ccr_regs ccr_regs_asserts i_chk (.clk, .rst, .clk_en, .avs_read, .avs_write, .avs_waitrequest,
    .avs_readdata, .auto_clamp_valid, .auto_clamp_code, .pos_arm_en_q, .neg_arm_en_q, .negative_clamp_code_q,
    .positive_clamp_code_q, .clamp_setting_mode_q, .track_mode_q, .mode_invalid_q, .nclamp_volt_ok_q,
    .pclamp_volt_ok_q);
`default_nettype wire

// *** sim/ccr_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_test;
    logic clk = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, auto_clamp_valid = 1'h0, cal = 1'h0;
    logic [7:0] avs_address = 8'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'h3, auto_clamp_code = 4'h0, negative_clamp_code_q, positive_clamp_code_q;
    logic [15:0] raw_data = 16'h1111, cal_data = 16'h2222, chan_data_q, rd;
    logic avs_waitrequest, pos_arm_en_q, neg_arm_en_q, track_mode_q;
    logic [1:0] clamp_setting_mode_q;
    logic clk_en = 1'h1, mode_invalid_q, nclamp_volt_ok_q, pclamp_volt_ok_q;
    int mismatches = 0, cmp_count = 0;
    typedef struct {logic [7:0] a; logic [15:0] d; logic [3:0] be; logic [15:0] e;} ccr_row_s;
    ccr_row_s rows [10] = '{'{8'h07, 16'h0001, 4'h3, 16'h0001}, '{8'h07, 16'h0002, 4'h3, 16'h0002},
        '{8'h07, 16'h0003, 4'h3, 16'h0003}, '{8'h07, 16'h041c, 4'h3, 16'h041c},
        '{8'h07, 16'hf2e9, 4'h3, 16'hf2e9}, '{8'h07, 16'h0c28, 4'h3, 16'h0c28},
        '{8'h07, 16'hffff, 4'h1, 16'h0cff}, '{8'h08, 16'hfffe, 4'h3, 16'hfffe},
        '{8'h08, 16'h0001, 4'h3, 16'h0001}, '{8'h04, 16'h1234, 4'h3, 16'h0000}};
    ccr_regs i_dut (.clk, .rst, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .auto_clamp_valid, .auto_clamp_code, .raw_data,
        .cal_data, .chan_data_q, .pos_arm_en_q, .neg_arm_en_q, .negative_clamp_code_q, .positive_clamp_code_q,
        .clamp_setting_mode_q, .track_mode_q, .mode_invalid_q, .nclamp_volt_ok_q, .pclamp_volt_ok_q);
    // ----
    // Tasks
    // ----
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= {16'h0, d};
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0)
            @(posedge clk);
        rd = avs_readdata[15:0];
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rst_chk();
        chk("pos_arm", pos_arm_en_q, 16'h0);
        chk("neg_arm", neg_arm_en_q, 16'h0);
        chk("nclamp", negative_clamp_code_q, 16'h0);
        chk("pclamp", positive_clamp_code_q, 16'h0);
        chk("track", track_mode_q, 16'h1);
        chk("chan", chan_data_q, 16'h0);
        rst <= 1'h0;
        @(posedge clk);
        bus(1'h0, 8'h07, 16'h0, 4'h3);
        chk("cfg_rst", rd, 16'h0);
        bus(1'h0, 8'h08, 16'h0, 4'h3);
        chk("cal_rst", rd, 16'h0);
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----
    // Sequence
    // ----
    initial
        forever #2.5 clk = ~clk;
    initial
    begin
        repeat (4000) @(posedge clk);
        mismatches++;
        stop_test();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst_chk();
        foreach (rows[i])
        begin
            bus(1'h1, rows[i].a, rows[i].d, rows[i].be);
            bus(1'h0, rows[i].a, 16'h0, 4'h3);
            chk("readback", rd, rows[i].e);
            if (rows[i].a == 8'h08)
                cal = rows[i].e[0];
            chk("chan", chan_data_q, cal ? cal_data : raw_data);
            if (rows[i].a == 8'h07)
            begin
                chk("pos_arm", pos_arm_en_q, rows[i].e[1:0] == 2'h1);
                chk("neg_arm", neg_arm_en_q, rows[i].e[1:0] == 2'h2);
                chk("nclamp", negative_clamp_code_q, rows[i].e[5:2]);
                chk("pclamp", positive_clamp_code_q, rows[i].e[9:6]);
                chk("mode", clamp_setting_mode_q, rows[i].e[11:10]);
                chk("nclamp_ok", nclamp_volt_ok_q, rows[i].e[5:2] inside {4'h2, 4'h7, 4'h9});
                chk("pclamp_ok", pclamp_volt_ok_q, rows[i].e[9:6] inside {4'h3, 4'h8, 4'h9});
                chk("invalid", mode_invalid_q, rows[i].e[11:10] == 2'h3);
                chk("track_row", track_mode_q, rows[i].e[11:10] == 2'h0);
            end
        end
        clk_en <= 1'h0;
        cal_data <= 16'h4444;
        raw_data <= 16'h3333;
        fork
            bus(1'h1, 8'h08, 16'h0, 4'h3);
            begin
                repeat (3) @(posedge clk);
                chk("frz_wait", avs_waitrequest, 16'h1);
                chk("frz_chan", chan_data_q, 16'h2222);
                clk_en <= 1'h1;
            end
        join
        chk("cal_off", chan_data_q, 16'h3333);
        bus(1'h0, 8'h08, 16'h0, 4'h3);
        chk("cal_clr", rd, 16'h0);
        bus(1'h1, 8'h07, 16'h0800, 4'h3);
        bus(1'h1, 8'h07, 16'h09c0, 4'h3);
        bus(1'h0, 8'h07, 16'h0, 4'h3);
        chk("auto_drop", rd, 16'h0800);
        auto_clamp_code <= 4'h5;
        auto_clamp_valid <= 1'h1;
        @(posedge clk);
        auto_clamp_valid <= 1'h0;
        bus(1'h0, 8'h07, 16'h0, 4'h3);
        chk("auto_load", rd, 16'h0940);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst_chk();
        stop_test();
    end
endmodule
`default_nettype wire
